// ==== hw/wwd_regs.vh ====
// Register map, field positions, reset values and timing counts of the windowed watchdog
`ifndef WWD_REGS_VH
`define WWD_REGS_VH

// Register indices; byte address is four times the index
`define WWD_CTRL_IDX 4'h0
`define WWD_STATUS_IDX 4'h1
`define WWD_UNLOCK_IDX 4'h2

// Control fields
`define WWD_WIN_MSB 7
`define WWD_WIN_LSB 4
`define WWD_PER_MSB 3
`define WWD_PER_LSB 0
`define WWD_CODE_MAX 4'hb

// Status fields
`define WWD_LOCK_BIT 7
`define WWD_BUSY_BIT 0

// Reset values
`define WWD_CTRL_RST 8'h00
`define WWD_STATUS_RST 8'h00

// Timed unlock key and how many bus accesses it stays armed
`define WWD_UNLOCK_KEY 8'hc5
`define WWD_UNLOCK_ACCESSES 3'd4

// Timing: system clock, watchdog clock, crossing length in watchdog clocks
`define WWD_CLK_HZ 10000000
`define WWD_WD_HZ 1000
`define WWD_TICK_DIV (`WWD_CLK_HZ / `WWD_WD_HZ)
`define WWD_SYNC_TICKS 2'd2

// AXI responses
`define WWD_RESP_OKAY 2'b00
`define WWD_RESP_SLVERR 2'b10

`endif

// ==== hw/wwd_tick.v ====
// Divider making the one-cycle watchdog clock enable from the system clock
`timescale 1ns/1ns
module wwd_tick #(
    parameter DIV = 10000
) (
    input wire aclk,
    input wire aresetn,
    output reg tick_q
);
    reg [15:0] cnt_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (cnt_q == DIV[15:0] - 16'h0001)
        begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
endmodule

// ==== hw/wwd_sync.v ====
// Carries a request into the watchdog time base, busy for one to two watchdog clocks
`timescale 1ns/1ns
`include "wwd_regs.vh"
module wwd_sync (
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire start,
    output reg busy_q,
    output reg done_q
);
    reg [1:0] ticks_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            ticks_q <= 2'd0;
        end
        else
        begin
            done_q <= 1'b0;
            if (!busy_q)
            begin
                if (start)
                begin
                    busy_q <= 1'b1;
                    ticks_q <= 2'd0;
                end
            end
            else if (tick)
            begin
                if (ticks_q == `WWD_SYNC_TICKS - 2'd1)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                begin
                    ticks_q <= ticks_q + 2'd1;
                end
            end
        end
    end
endmodule

// ==== hw/wwd_top.v ====
// Windowed watchdog: AXI4-Lite registers, lock, timed unlock and window timing
`timescale 1ns/1ns
`include "wwd_regs.vh"
// Functional notes
// - Nonzero upper field selects window operation
// - Upper code sets closed window, 8 doubling
// - Nonzero lower field enables the watchdog
// - Lower code sets timeout, 8 doubling
// - Lower code sets open window length
// - Lock makes control fields read-only
// - Lock bit is set by software writes or at boot by a nonzero fuse period
// - Lock clears only in debug mode
// - Nonzero boot period sets lock automatically
// - Control write raises cross-domain pending
// - Pending clears itself; read-only to software
// - Lock written only after timed unlock
// - Pending flag ignores timed unlock
// - Control reset value comes from fuse
// - Kick in closed window resets system
module wwd_top #(
    parameter TICK_DIV = `WWD_TICK_DIV
) (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] boot_config_fuse,
    input wire boot_done,
    input wire debug_halt,
    input wire kick_instruction,
    output reg system_reset_q,
    output wire watchdog_enabled
);
    localparam PH_OPEN = 1'b0;
    localparam PH_CLOSED = 1'b1;

    // Length in watchdog clocks of a period code, minus one
    function [13:0] wwd_len;
        input [3:0] code;
        begin
            if (code == 4'h0 || code > `WWD_CODE_MAX)
                wwd_len = 14'h1fff;
            else
                wwd_len = (14'h0008 << (code - 4'h1)) - 14'h0001;
        end
    endfunction

    reg [7:0] ctrl_q;
    reg lock_q;
    reg booted_q;
    reg [2:0] armed_q;
    reg aw_held_q;
    reg w_held_q;
    reg [3:0] aw_idx_q;
    reg [7:0] wdata_q;
    reg wstrb0_q;
    reg [7:0] wctl_q;
    reg phase_q;
    reg first_q;
    reg [13:0] cnt_q;
    reg ctrl_start;
    wire tick;
    wire ctrl_busy;
    wire ctrl_done;
    wire kick_done;
    wire wr_go;
    wire rd_go;
    wire wr_ctrl;
    wire wr_lock;
    wire [3:0] ar_idx;
    wire [3:0] win_code;
    wire [3:0] per_code;

    wwd_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_q(tick)
    );

    wwd_sync u_ctrl_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(ctrl_start),
        .busy_q(ctrl_busy),
        .done_q(ctrl_done)
    );

    wwd_sync u_kick_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(kick_instruction),
        .busy_q(),
        .done_q(kick_done)
    );

    // Write channels are taken independently and held until the response
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ar_idx = s_axi_araddr[5:2];

    assign wr_ctrl = wr_go && wstrb0_q && aw_idx_q == `WWD_CTRL_IDX
        && armed_q != 3'd0 && !lock_q;
    // only a one sets the lock
    assign wr_lock = wr_go && wstrb0_q && aw_idx_q == `WWD_STATUS_IDX
        && armed_q != 3'd0 && wdata_q[`WWD_LOCK_BIT];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= 4'h0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `WWD_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_idx_q == `WWD_CTRL_IDX || aw_idx_q == `WWD_STATUS_IDX
                    || aw_idx_q == `WWD_UNLOCK_IDX)
                    s_axi_bresp <= `WWD_RESP_OKAY;
                else
                    s_axi_bresp <= `WWD_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read path; status shows lock and the crossing flag
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `WWD_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `WWD_RESP_OKAY;
            if (ar_idx == `WWD_CTRL_IDX)
                s_axi_rdata <= {24'h000000, ctrl_q};
            else if (ar_idx == `WWD_STATUS_IDX)
                s_axi_rdata <= {24'h000000, lock_q, 6'b000000, ctrl_busy};
            else if (ar_idx == `WWD_UNLOCK_IDX)
                s_axi_rdata <= 32'h00000000;
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `WWD_RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Timed unlock stays armed for the next few bus accesses
    always @(posedge aclk)
    begin
        if (!aresetn)
            armed_q <= 3'd0;
        else if (wr_go && wstrb0_q && aw_idx_q == `WWD_UNLOCK_IDX
            && wdata_q == `WWD_UNLOCK_KEY)
            armed_q <= `WWD_UNLOCK_ACCESSES;
        else if (wr_ctrl || wr_lock)
            armed_q <= 3'd0;
        else if ((wr_go || rd_go) && armed_q != 3'd0)
            armed_q <= armed_q - 3'd1;
    end

    // Control, lock and boot loading
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= `WWD_CTRL_RST;
            lock_q <= |(`WWD_STATUS_RST & (8'h01 << `WWD_LOCK_BIT));
            booted_q <= 1'b0;
            ctrl_start <= 1'b0;
        end
        else
        begin
            ctrl_start <= 1'b0;
            if (!booted_q)
            begin
                if (boot_done)
                begin
                    booted_q <= 1'b1;
                    ctrl_q <= boot_config_fuse;
                    ctrl_start <= 1'b1;
                    lock_q <= boot_config_fuse[`WWD_PER_MSB:`WWD_PER_LSB] != 4'h0;
                end
            end
            else
            begin
                if (wr_ctrl)
                begin
                    ctrl_q <= wdata_q;
                    ctrl_start <= 1'b1;
                end
                if (debug_halt)
                    lock_q <= 1'b0;
                else if (wr_lock)
                    lock_q <= 1'b1;
            end
        end
    end

    assign win_code = wctl_q[`WWD_WIN_MSB:`WWD_WIN_LSB];
    assign per_code = wctl_q[`WWD_PER_MSB:`WWD_PER_LSB];
    assign watchdog_enabled = per_code != 4'h0;

    // Watchdog time base, advanced by the watchdog clock enable
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wctl_q <= `WWD_CTRL_RST;
            phase_q <= PH_OPEN;
            first_q <= 1'b1;
            cnt_q <= 14'h0000;
            system_reset_q <= 1'b0;
        end
        else
        begin
            system_reset_q <= 1'b0;
            if (ctrl_done)
            begin
                wctl_q <= ctrl_q;
                if (ctrl_q[`WWD_WIN_MSB:`WWD_WIN_LSB] != 4'h0 && win_code == 4'h0)
                begin
                    first_q <= 1'b1;
                    phase_q <= PH_OPEN;
                end
            end
            if (!watchdog_enabled || debug_halt)
            begin
                cnt_q <= 14'h0000;
                phase_q <= PH_OPEN;
                if (debug_halt)
                    first_q <= 1'b1;
            end
            else if (kick_done)
            begin
                if (phase_q == PH_CLOSED && win_code != 4'h0)
                    system_reset_q <= 1'b1;
                cnt_q <= 14'h0000;
                first_q <= 1'b0;
                phase_q <= (win_code != 4'h0) ? PH_CLOSED : PH_OPEN;
            end
            else if (tick)
            begin
                if (phase_q == PH_CLOSED && (win_code == 4'h0 || cnt_q >= wwd_len(win_code)))
                begin
                    phase_q <= PH_OPEN;
                    cnt_q <= 14'h0000;
                end
                else if (phase_q == PH_OPEN && cnt_q >= wwd_len(per_code))
                begin
                    system_reset_q <= 1'b1;
                    cnt_q <= 14'h0000;
                    phase_q <= (win_code != 4'h0 && !first_q) ? PH_CLOSED : PH_OPEN;
                end
                else
                begin
                    cnt_q <= cnt_q + 14'h0001;
                end
            end
        end
    end
endmodule

// ==== testbench/wwd_checker.sv ====
// Concurrent checks on the windowed watchdog ports
`timescale 1ns/1ns
module wwd_checker #(
    parameter TICK_DIV = 10
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire debug_halt,
    input wire kick_instruction,
    input wire system_reset_q,
    input wire watchdog_enabled
);
    // Longest closed plus open span, with slack for the crossing
    localparam int LIM = 16384 * TICK_DIV + 400;
    logic [3:0] ra_q;
    logic [31:0] cnt_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            ra_q <= s_axi_araddr[5:2];
        if (!aresetn || !watchdog_enabled || debug_halt || kick_instruction || system_reset_q)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_q + 32'h1;
    end
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_stat;
        s_axi_rvalid && ra_q == 4'h1 |-> s_axi_rdata[31:8] == 0 && s_axi_rdata[6:1] == 0;
    endproperty
    a_stat: assert property (p_stat) else $error("status spare bits set");
    property p_pulse;
        system_reset_q |=> !system_reset_q;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse too long");
    property p_off;
        !watchdog_enabled && !$past(watchdog_enabled) |-> !system_reset_q;
    endproperty
    a_off: assert property (p_off) else $error("reset while disabled");
    property p_dbg;
        debug_halt && $past(debug_halt) |-> !system_reset_q;
    endproperty
    a_dbg: assert property (p_dbg) else $error("reset while halted");
    property p_exp;
        cnt_q < LIM;
    endproperty
    a_exp: assert property (p_exp) else $error("no reset after expiry");
endmodule

bind wwd_top wwd_checker #(.TICK_DIV(TICK_DIV)) u_chk (.*);

// ==== testbench/tb_top.sv ====
// Self-checking bench for the windowed watchdog registers
`timescale 1ns/1ns
`include "wwd_regs.vh"
module tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, boot_done, debug_halt, kick_instruction, system_reset_q;
    logic watchdog_enabled;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] boot_config_fuse, v;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int fail_count, n_tests, nrst, n0;
    localparam logic [5:0] a_ctl = {`WWD_CTRL_IDX, 2'h0};
    localparam logic [5:0] a_st = {`WWD_STATUS_IDX, 2'h0};
    localparam logic [5:0] a_key = {`WWD_UNLOCK_IDX, 2'h0};
    localparam logic [1:0] ok = `WWD_RESP_OKAY;
    wwd_top #(.TICK_DIV(10)) dut (.*);
    initial
    begin
        aclk = 0;
        forever #50 aclk = ~aclk;
    end
    task chk_rd(input [33:0] e, input [33:0] g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task chk_wr(input [1:0] e, input [1:0] g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task chk_lvl(input [31:0] e, input [31:0] g);
        n_tests++;
        if (e !== g)
        begin
            fail_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task wr(input [5:0] a, input [31:0] d, input [1:0] r);
        logic aw, w;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        aw = 0;
        w = 0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        wt($urandom_range(2, 0));
        s_axi_bready <= 1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task rd(input [5:0] a, input [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        wt($urandom_range(2, 0));
        s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    task pw(input [5:0] a, input [7:0] d);
        wr(a_key, {24'h0, `WWD_UNLOCK_KEY}, ok);
        wr(a, {24'h0, d}, ok);
    endtask
    task kk;
        @(posedge aclk);
        kick_instruction <= 1;
        @(posedge aclk);
        kick_instruction <= 0;
    endtask
    task conclude;
        $display("tests=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Result monitor pops the oldest note per answer
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            chk_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk_wr(bq.pop_front(), s_axi_bresp);
        if (system_reset_q)
            nrst++;
    end
    initial
    begin
        wt(20000);
        fail_count++;
        conclude;
    end
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn,
            debug_halt, kick_instruction, s_axi_awaddr, s_axi_araddr, s_axi_wdata,
            boot_config_fuse} = 0;
        s_axi_wstrb = 4'hf;
        boot_done = 1;
        void'($urandom(98));
        wt(10);
        aresetn <= 1;
        wt(40);
        rd(a_ctl, 0);
        rd(a_st, 0);
        chk_lvl(0, watchdog_enabled);
        wr(a_ctl, 32'h11, ok);
        rd(a_ctl, 0);
        wt(40);
        for (int k = 1; k < 12; k++)
        begin
            v = {4'($urandom_range(11, 0)), 4'(k)};
            pw(a_ctl, v);
            rd(a_ctl, v);
            rd(a_st, 1);
            wt(40);
            rd(a_st, 0);
        end
        chk_lvl(1, watchdog_enabled);
        pw(a_ctl, 8'h01);
        wt(40);
        kk;
        wt(40);
        n0 = nrst;
        repeat (8)
        begin
            kk;
            wt(40);
        end
        chk_lvl(n0, nrst);
        wt(100);
        chk_lvl(n0 + 1, nrst);
        pw(a_ctl, 8'h11);
        wt(40);
        kk;
        wt(40);
        n0 = nrst;
        kk;
        wt(40);
        chk_lvl(n0 + 1, nrst);
        n0 = nrst;
        // Kick lands in the open window, then closed plus open runs out
        wt(60);
        kk;
        wt(100);
        chk_lvl(n0, nrst);
        wt(100);
        chk_lvl(n0 + 1, nrst);
        wr(a_st, 32'h80, ok);
        rd(a_st, 0);
        pw(a_st, 8'h80);
        rd(a_st, 34'h80);
        pw(a_st, 8'h00);
        rd(a_st, 34'h80);
        pw(a_ctl, 8'h00);
        rd(a_ctl, 34'h11);
        wt(40);
        debug_halt <= 1;
        wt(5);
        debug_halt <= 0;
        rd(a_st, 0);
        rd(6'h0c, {`WWD_RESP_SLVERR, 32'h0});
        wr(6'h10, 32'h0, `WWD_RESP_SLVERR);
        aresetn <= 0;
        boot_config_fuse <= 8'h03;
        wt(2);
        aresetn <= 1;
        rd(a_ctl, 34'h03);
        rd(a_st, 34'h81);
        conclude;
    end
endmodule
